// ==== rtl/adcseq_pkg.sv ====
package adcseq_pkg;
	// ----------------------------------------
	// Timing and channel count
	// ----------------------------------------
	localparam int CLK_PERIOD_NS     = 10;
	localparam int CONV_PER_CH_NS    = 550;
	localparam int CONV_PER_CH_CYC   = CONV_PER_CH_NS / CLK_PERIOD_NS;
	localparam int PULSE_NS          = 50;
	localparam int PULSE_CYC         = PULSE_NS / CLK_PERIOD_NS;
	localparam int ACQ_NS            = 625;
	localparam int ACQ_CYC           =
		(ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NAP_LOW_NS        = 750;
	localparam int NAP_LOW_CYC       =
		(NAP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_MS           = 10;
	localparam int INIT_BUF_MS       = 200;
	localparam int INIT_CYC          = INIT_MS * 100000;
	localparam int INIT_BUF_CYC      = INIT_BUF_MS * 100000;
	localparam int INIT_INT_CYC      = 16;
	localparam int NUM_CH            = 4;

	typedef enum logic [2:0] {
		ADCSEQ_INIT  = 3'b000,
		ADCSEQ_ACQ   = 3'b001,
		ADCSEQ_CONV  = 3'b010,
		ADCSEQ_NAP   = 3'b011,
		ADCSEQ_PDOWN = 3'b100
	} adcseq_state_t;

	typedef enum logic [1:0] {
		ADCSEQ_H_WAIT  = 2'b00,
		ADCSEQ_H_IDLE  = 2'b01,
		ADCSEQ_H_PULSE = 2'b10,
		ADCSEQ_H_BUSY  = 2'b11
	} adcseq_hstate_t;
endpackage

// ==== rtl/adcseq_if.sv ====
`timescale 1ns/100ps
interface adcseq_if;
	logic conversion_start;
	logic power_down_request;
	logic busy;

	modport device (
		input  conversion_start,
		input  power_down_request,
		output busy
	);
	modport host (
		output conversion_start,
		output power_down_request,
		input  busy
	);
endinterface

// ==== rtl/adcseq_device.sv ====
`timescale 1ns/100ps
module adcseq_device #(
	parameter int INIT_CYCLES = adcseq_pkg::INIT_INT_CYC,
	parameter int NUM_CH      = adcseq_pkg::NUM_CH
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	adcseq_if.device         link,
	input  wire logic [3:0]  chan_enable,
	output logic             sample_hold,
	output logic             nap_active,
	output logic             power_down_active,
	output logic             init_active,
	output logic             conv_done
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] cnv_sync_reg;
	logic [2:0] pd_sync_reg;
	logic       cnv_reg;
	logic       cnv_next;
	logic       pd_reg;
	logic       pd_next;

	// Change counts once the second and third stages agree
	always_comb begin
		cnv_next = cnv_reg;
		pd_next  = pd_reg;
		if (cnv_sync_reg[1] == cnv_sync_reg[2])
			cnv_next = cnv_sync_reg[2];
		if (pd_sync_reg[1] == pd_sync_reg[2])
			pd_next = pd_sync_reg[2];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnv_sync_reg <= 3'h0;
			pd_sync_reg  <= 3'h0;
			cnv_reg      <= 1'b0;
			pd_reg       <= 1'b0;
		end else if (clk_en) begin
			cnv_sync_reg <= {cnv_sync_reg[1:0], link.conversion_start};
			pd_sync_reg  <= {pd_sync_reg[1:0], link.power_down_request};
			cnv_reg      <= cnv_next;
			pd_reg       <= pd_next;
		end
	end

	logic cnv_rise;
	logic pd_rise;
	assign cnv_rise = cnv_next & ~cnv_reg;
	assign pd_rise  = pd_next & ~pd_reg;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	adcseq_pkg::adcseq_state_t state_reg;
	adcseq_pkg::adcseq_state_t state_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic        pd_armed_reg;
	logic        pd_armed_next;
	logic        busy_reg;
	logic        busy_next;
	logic        hold_reg;
	logic        hold_next;
	logic        done_reg;
	logic        done_next;
	logic [2:0]  nch;
	logic [31:0] conv_len;

	// Zero enabled channels still costs one slot
	always_comb begin
		nch = 3'h0;
		for (int i = 0; i < NUM_CH; i++)
			nch = nch + {2'h0, chan_enable[i]};
		if (nch == 3'h0)
			nch = 3'h1;
		conv_len = 32'(adcseq_pkg::CONV_PER_CH_CYC) * {29'h0, nch};
	end

	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		pd_armed_next = pd_armed_reg;
		busy_next     = busy_reg;
		hold_next     = hold_reg;
		done_next     = 1'b0;
		// Second power-down rise with no conversion between
		if (pd_rise && pd_armed_reg) begin
			state_next    = adcseq_pkg::ADCSEQ_INIT;
			cnt_next      = 32'h0;
			busy_next     = 1'b0;
			hold_next     = 1'b0;
			pd_armed_next = 1'b0;
		end else begin
			if (pd_rise)
				pd_armed_next = 1'b1;
			case (state_reg)
			adcseq_pkg::ADCSEQ_INIT: begin
				if (cnt_reg >= 32'(INIT_CYCLES) - 32'h1) begin
					state_next = adcseq_pkg::ADCSEQ_ACQ;
					cnt_next   = 32'h0;
				end else begin
					cnt_next = cnt_reg + 32'h1;
				end
			end
			adcseq_pkg::ADCSEQ_ACQ,
			adcseq_pkg::ADCSEQ_NAP: begin
				// Sampling track runs while start is low
				if (state_reg == adcseq_pkg::ADCSEQ_NAP && !cnv_reg)
					state_next = adcseq_pkg::ADCSEQ_ACQ;
				if (pd_reg) begin
					state_next = adcseq_pkg::ADCSEQ_PDOWN;
				end else if (cnv_rise) begin
					state_next    = adcseq_pkg::ADCSEQ_CONV;
					hold_next     = 1'b1;
					busy_next     = 1'b1;
					// Set wins over a same-cycle start
					pd_armed_next = pd_rise;
					cnt_next      = 32'h0;
				end
			end
			adcseq_pkg::ADCSEQ_CONV: begin
				// Start edges here do nothing; only sys_rst or a second power-down rise stops it
				if (cnt_reg >= conv_len - 32'h1) begin
					busy_next = 1'b0;
					hold_next = 1'b0;
					done_next = 1'b1;
					cnt_next  = 32'h0;
					if (pd_reg)
						state_next = adcseq_pkg::ADCSEQ_PDOWN;
					else if (cnv_reg)
						state_next = adcseq_pkg::ADCSEQ_NAP;
					else
						state_next = adcseq_pkg::ADCSEQ_ACQ;
				end else begin
					cnt_next = cnt_reg + 32'h1;
				end
			end
			adcseq_pkg::ADCSEQ_PDOWN: begin
				if (!pd_reg) begin
					state_next = adcseq_pkg::ADCSEQ_INIT;
					cnt_next   = 32'h0;
				end
			end
			default: state_next = adcseq_pkg::ADCSEQ_INIT;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg    <= adcseq_pkg::ADCSEQ_INIT;
			cnt_reg      <= 32'h0;
			pd_armed_reg <= 1'b0;
			busy_reg     <= 1'b0;
			hold_reg     <= 1'b0;
			done_reg     <= 1'b0;
		end else if (clk_en) begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			pd_armed_reg <= pd_armed_next;
			busy_reg     <= busy_next;
			hold_reg     <= hold_next;
			done_reg     <= done_next;
		end
	end

	assign link.busy         = busy_reg;
	assign sample_hold       = hold_reg;
	assign conv_done         = done_reg;
	assign nap_active        = (state_reg == adcseq_pkg::ADCSEQ_NAP);
	assign power_down_active = (state_reg == adcseq_pkg::ADCSEQ_PDOWN);
	assign init_active       = (state_reg == adcseq_pkg::ADCSEQ_INIT);
endmodule

// ==== rtl/adcseq_host.sv ====
`timescale 1ns/100ps
module adcseq_host #(
	parameter int  INIT_CYCLES = adcseq_pkg::INIT_CYC,
	parameter int  INIT_BUF_CYCLES = adcseq_pkg::INIT_BUF_CYC,
	parameter int  LOW_CYCLES  = adcseq_pkg::NAP_LOW_CYC
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	adcseq_if.host    link,
	input  wire logic use_ref_buffer,
	input  wire logic start_req,
	input  wire logic nap_hold,
	input  wire logic pd_req,
	output logic      ready,
	output logic      conv_done
);
	// ----------------------------------------
	// Busy synchroniser
	// ----------------------------------------
	logic [2:0] busy_sync_reg;
	logic       busy_reg;
	logic       busy_next;

	always_comb begin
		busy_next = busy_reg;
		if (busy_sync_reg[1] == busy_sync_reg[2])
			busy_next = busy_sync_reg[2];
	end

	// ----------------------------------------
	// Start pulse sequencer
	// ----------------------------------------
	adcseq_pkg::adcseq_hstate_t state_reg;
	adcseq_pkg::adcseq_hstate_t state_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic [31:0] low_reg;
	logic [31:0] low_next;
	logic        cnv_reg;
	logic        cnv_next;
	logic        pd_reg;
	logic        pd_next;
	logic        done_reg;
	logic        done_next;
	logic [31:0] wait_len;

	// Buffer recharge needs the longer hold-off
	assign wait_len = use_ref_buffer ? 32'(INIT_BUF_CYCLES)
		: 32'(INIT_CYCLES);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		cnv_next   = cnv_reg;
		pd_next    = pd_req;
		done_next  = 1'b0;
		// Low time covers acquisition and nap exit
		low_next   = cnv_reg ? 32'h0 : low_reg + 32'h1;
		case (state_reg)
		adcseq_pkg::ADCSEQ_H_WAIT: begin
			if (cnt_reg >= wait_len) begin
				state_next = adcseq_pkg::ADCSEQ_H_IDLE;
			end else begin
				cnt_next = cnt_reg + 32'h1;
			end
			if (pd_reg && !pd_req)
				cnt_next = 32'h0;
		end
		adcseq_pkg::ADCSEQ_H_IDLE: begin
			if (pd_reg) begin
				state_next = adcseq_pkg::ADCSEQ_H_WAIT;
				cnt_next   = 32'h0;
			end else if (start_req && !cnv_reg
				&& low_reg >= 32'(LOW_CYCLES)) begin
				state_next = adcseq_pkg::ADCSEQ_H_PULSE;
				cnv_next   = 1'b1;
				cnt_next   = 32'h0;
			end else if (!nap_hold) begin
				cnv_next = 1'b0;
			end
		end
		adcseq_pkg::ADCSEQ_H_PULSE: begin
			// Drop inside the 40 to 60 ns window, or stay high while nap_hold is set
			if (cnt_reg >= 32'(adcseq_pkg::PULSE_CYC) - 32'h1) begin
				cnv_next   = nap_hold;
				state_next = adcseq_pkg::ADCSEQ_H_BUSY;
				cnt_next   = 32'h0;
			end else begin
				cnt_next = cnt_reg + 32'h1;
			end
		end
		adcseq_pkg::ADCSEQ_H_BUSY: begin
			if (cnt_reg < 32'h8)
				cnt_next = cnt_reg + 32'h1;
			else if (!busy_reg) begin
				done_next  = 1'b1;
				state_next = adcseq_pkg::ADCSEQ_H_IDLE;
			end
		end
		default: state_next = adcseq_pkg::ADCSEQ_H_WAIT;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			busy_sync_reg <= 3'h0;
			busy_reg      <= 1'b0;
			state_reg     <= adcseq_pkg::ADCSEQ_H_WAIT;
			cnt_reg       <= 32'h0;
			low_reg       <= 32'h0;
			cnv_reg       <= 1'b0;
			pd_reg        <= 1'b0;
			done_reg      <= 1'b0;
		end else if (clk_en) begin
			busy_sync_reg <= {busy_sync_reg[1:0], link.busy};
			busy_reg      <= busy_next;
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			low_reg       <= low_next;
			cnv_reg       <= cnv_next;
			pd_reg        <= pd_next;
			done_reg      <= done_next;
		end
	end

	assign link.conversion_start   = cnv_reg;
	assign link.power_down_request = pd_reg;
	assign ready     = (state_reg == adcseq_pkg::ADCSEQ_H_IDLE) && !cnv_reg
		&& low_reg >= 32'(LOW_CYCLES);
	assign conv_done = done_reg;
endmodule

// ==== tb/adcseq_asserts.sv ====
`timescale 1ns/100ps
module adcseq_asserts (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic conversion_start,
	input wire logic power_down_request,
	input wire logic busy
);
	localparam int CONV_MAX =
		adcseq_pkg::CONV_PER_CH_CYC * adcseq_pkg::NUM_CH;
	logic [8:0] cnt_reg;
	logic [8:0] cnt_next;

	// ----------------------------------------
	// Busy length
	// ----------------------------------------
	always_comb begin
		cnt_next = busy ? cnt_reg + 9'h001 : 9'h000;
	end
	always_ff @(posedge ref_clk) begin
		cnt_reg <= sys_rst ? 9'h000 : cnt_next;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	a_start_to_busy: assert property ($rose(conversion_start) && !busy
		&& !power_down_request |-> ##[2:5] busy)
		else $error("busy did not follow start");
	a_busy_has_cause: assert property ($rose(busy)
		|-> $past(conversion_start, 2))
		else $error("busy rose without start");
	a_busy_bound: assert property (cnt_reg <= CONV_MAX)
		else $error("conversion too long");
	a_busy_full_len: assert property ($fell(busy) && !power_down_request
		|-> cnt_reg inside {9'h037, 9'h06e, 9'h0a5, 9'h0dc})
		else $error("busy length wrong");
	a_no_abort: assert property (busy && !power_down_request
		&& !(cnt_reg inside {9'h036, 9'h06d, 9'h0a4, 9'h0db}) |=> busy)
		else $error("conversion cut short");
	a_no_retrigger: assert property ($fell(busy) |-> !busy [*4])
		else $error("busy restarted at once");
	a_nap_stays: assert property (!busy && conversion_start
		&& $past(conversion_start, 8) |=> !busy)
		else $error("conversion while napping");
	a_reset_idle: assert property ($fell(sys_rst) |-> !busy [*8])
		else $error("busy during init");

	c_full: cover property ($fell(busy) && cnt_reg == 9'h0dc);
	c_nap: cover property ($fell(busy) && conversion_start);
	c_abort: cover property ($fell(busy) && power_down_request);
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	logic       ref_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       use_buf = 1'b0;
	logic       start_req = 1'b0;
	logic       nap_hold = 1'b0;
	logic       pd_req = 1'b0;
	logic [3:0] chan_en = 4'hf;
	logic       ready;
	logic       h_done;
	logic       d_done;
	logic       hold;
	logic       nap;
	logic       init;
	logic       pdn;
	int         fail_count = 0;
	int         checks = 0;
	int         hd_n = 0;
	int         dd_n = 0;
	int         low_n = 0;
	int         last_low = 0;
	int         n;
	int         k;

	adcseq_if link ();
	always #5 ref_clk = ~ref_clk;

	adcseq_host #(.INIT_CYCLES(100), .INIT_BUF_CYCLES(200)) u_adcseq_host (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .link(link),
		.use_ref_buffer(use_buf), .start_req(start_req),
		.nap_hold(nap_hold), .pd_req(pd_req), .ready(ready),
		.conv_done(h_done));
	adcseq_device u_adcseq_device (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .link(link),
		.chan_enable(chan_en), .sample_hold(hold), .nap_active(nap),
		.power_down_active(pdn), .init_active(init), .conv_done(d_done));
	adcseq_asserts u_adcseq_asserts (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.conversion_start(link.conversion_start),
		.power_down_request(link.power_down_request), .busy(link.busy));

	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (h_done === 1'b1)
			hd_n <= hd_n + 1;
		if (d_done === 1'b1)
			dd_n <= dd_n + 1;
		if (link.conversion_start === 1'b0)
			low_n <= low_n + 1;
		else begin
			if (low_n > 0)
				last_low <= low_n;
			low_n <= 0;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s exp %0d seen %0d", what, exp, seen);
		end
	endtask

	task close_out;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task cyc(input int c);
		repeat (c) @(negedge ref_clk);
	endtask

	// Bounded: a hang ends the run as a mismatch
	task automatic wait_for(input string what, input logic on_busy,
		input logic v, input int lim);
		logic s;
		s = on_busy ? link.busy : ready;
		for (int i = 0; i < lim && s !== v; i++) begin
			@(negedge ref_clk);
			s = on_busy ? link.busy : ready;
		end
		if (s !== v) begin
			chk(what, 9'h000, 9'h001);
			close_out();
		end
	endtask

	task automatic run_conv(input int exp_len);
		int len;
		len = 0;
		wait_for("ready", 1'b0, 1'b1, 400);
		start_req = 1'b1;
		wait_for("busy rise", 1'b1, 1'b1, 20);
		start_req = 1'b0;
		chk("hold", hold, 1'b1);
		while (link.busy === 1'b1 && len < 300) begin
			len++;
			@(negedge ref_clk);
		end
		chk("busy length", len[8:0], exp_len[8:0]);
		chk("hold release", hold, 1'b0);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		cyc(6);
		sys_rst = 1'b0;
		cyc(99);
		chk("ready early", ready, 1'b0);
		for (n = 0; n < 5; n++) begin
			chan_en = (n < 4) ? 4'hf >> (3 - n) : 4'h0;
			k = $countones(chan_en);
			// Zero enabled still converts one slot
			run_conv(adcseq_pkg::CONV_PER_CH_CYC * (k == 0 ? 1 : k));
		end
		$display("test channels done");
		chan_en = 4'hf;
		nap_hold = 1'b1;
		run_conv(220);
		cyc(3);
		chk("nap", nap, 1'b1);
		cyc(100);
		chk("nap busy", link.busy, 1'b0);
		nap_hold = 1'b0;
		run_conv(220);
		// The host done pulse trails the busy fall by the host synchroniser
		cyc(10);
		k = adcseq_pkg::NAP_LOW_CYC;
		chk("low time", 9'(last_low >= k), 9'h001);
		chk("host done", hd_n[8:0], 9'h007);
		chk("dev done", dd_n[8:0], 9'h007);
		$display("test nap done");
		start_req = 1'b1;
		wait_for("busy rise", 1'b1, 1'b1, 200);
		start_req = 1'b0;
		cyc(20);
		pd_req = 1'b1;
		cyc(5);
		pd_req = 1'b0;
		cyc(5);
		chk("busy first pd", link.busy, 1'b1);
		pd_req = 1'b1;
		cyc(8);
		chk("busy abort", link.busy, 1'b0);
		pd_req = 1'b0;
		cyc(40);
		run_conv(220);
		pd_req = 1'b1;
		cyc(8);
		chk("power down", pdn, 1'b1);
		pd_req = 1'b0;
		cyc(8);
		chk("power down exit", pdn, 1'b0);
		chk("reinit", init, 1'b1);
		$display("test global reset done");
		use_buf = 1'b1;
		start_req = 1'b1;
		wait_for("busy rise", 1'b1, 1'b1, 200);
		start_req = 1'b0;
		sys_rst = 1'b1;
		cyc(2);
		chk("busy reset", link.busy, 1'b0);
		chk("init", init, 1'b1);
		cyc(4);
		sys_rst = 1'b0;
		cyc(5);
		chk("init hold", init, 1'b1);
		// Past the short hold-off, still short of the buffered one
		cyc(140);
		chk("ready buffer", ready, 1'b0);
		wait_for("ready buffer late", 1'b0, 1'b1, 100);
		$display("test reset done");
		close_out();
	end
endmodule
